// [design/fuse_config_loader.sv]
// Fuse loader: reads the fuse image at reset and configures peripherals
module fuse_config_loader
  import fuse_config_pkg::*;
#(
  parameter int FLASH_BYTES  = 4096,
  parameter int MS_CYCLES    = CYCLES_PER_MS,
  parameter int HOLD_SLOW    = PIN_HOLD_SLOW
)(
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Fuse array read port, data one cycle after address
  output logic [3:0]       fuseAddr,
  input  wire logic [7:0]  fuseData,
  // Factory calibration values
  input  wire logic [6:0]  factCoarse16,
  input  wire logic [3:0]  factTemp16,
  input  wire logic [6:0]  factCoarse20,
  input  wire logic [3:0]  factTemp20,
  // Slow oscillator from outside this domain
  input  wire logic        slowOsc,
  // Debug and erase requests
  input  wire logic        debugBusReq,
  input  wire logic        chipErase,
  // Loaded configuration
  output logic [3:0]       watchdogWindow,
  output logic [3:0]       watchdogPeriod,
  output logic [2:0]       brownoutLevel,
  output logic             brownoutSampleRate,
  output logic [1:0]       brownoutActiveMode,
  output logic [1:0]       brownoutSleepMode,
  output logic             oscCalibrationLock,
  output logic             oscRun20,
  output logic [6:0]       oscCoarseCalibration,
  output logic [3:0]       oscTemperatureCalibration,
  output logic [7:0]       timerDFaultControl,
  output logic [1:0]       crcScanSource,
  output logic [1:0]       resetPinFunction,
  output logic             gpioDriveAllowed,
  output logic             eepromErase,
  output logic [15:0]      bootEndByte,
  output logic [15:0]      appEndByte,
  output logic             memoryLocked,
  output logic             debugBusGrant,
  output logic             periphResetHold,
  output logic             cpuResetHold
);

  localparam int MS_W   = $clog2(MS_CYCLES + 1);
  localparam int HOLD_W = $clog2(HOLD_SLOW + 1);

  load_state_type state_ff;
  logic [7:0]  fuse_ff [0:15];
  logic [3:0]  rdIdx_ff;
  logic        capValid_ff;
  logic [3:0]  capIdx_ff;
  logic [6:0]  coarse_ff;
  logic [3:0]  tempCal_ff;
  logic        calLock_ff;
  logic [MS_W-1:0]  msCnt_ff;
  logic        msTick;
  logic [6:0]  msElapsed_ff;
  logic [2:0]  slowSync_ff;
  logic        slowLevel_ff;
  logic [HOLD_W-1:0] holdCnt_ff;
  logic        holdDone_ff;
  logic        slowRise;
  logic        loaded;
  logic [5:0]  regIdx;
  logic        apbWrite;

  function automatic logic [6:0] delayMs(input logic [2:0] code);
    delayMs = (code == 3'h0) ? 7'h00 : 7'(1 << (code - 3'h1));
  endfunction : delayMs

  function automatic logic [15:0] blockBytes(input logic [7:0] blocks);
    blockBytes = 16'({8'h00, blocks} << BLOCK_SHIFT);
  endfunction : blockBytes

  assign loaded = (state_ff != ST_LOAD);

  // Load sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_ff    <= ST_LOAD;
      rdIdx_ff    <= 4'h0;
      capValid_ff <= 1'b0;
      capIdx_ff   <= 4'h0;
    end
    else
    begin
      capValid_ff <= (state_ff == ST_LOAD) && (rdIdx_ff <= LAST_FUSE_IDX);
      capIdx_ff   <= rdIdx_ff;
      case (state_ff)
        ST_LOAD:
        begin
          if (rdIdx_ff <= LAST_FUSE_IDX)
            rdIdx_ff <= rdIdx_ff + 4'h1;
          else if (!capValid_ff)
            state_ff <= ST_STARTUP;
        end
        ST_STARTUP:
        begin
          if (msElapsed_ff >= delayMs(fuse_ff[SYSTEM_ONE_IDX][DELAY_LSB +: 3]))
            state_ff <= ST_RUN;
        end
        ST_RUN:
          state_ff <= ST_RUN;
        default:
          state_ff <= ST_LOAD;
      endcase
    end
  end

  assign fuseAddr = rdIdx_ff;

  // Fuse image; lock key may also be rewritten over the bus
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 16; i++)
        fuse_ff[i] <= 8'h00;
    end
    else if (capValid_ff)
      fuse_ff[capIdx_ff] <= fuseData;
    else if (apbWrite && regIdx == 6'(LOCK_KEY_FUSE_IDX))
      fuse_ff[LOCK_KEY_FUSE_IDX] <= pwdata[7:0];
  end

  assign watchdogWindow     = fuse_ff[WATCHDOG_FUSE_IDX][WDT_WINDOW_LSB +: 4];
  assign watchdogPeriod     = fuse_ff[WATCHDOG_FUSE_IDX][WDT_PERIOD_LSB +: 4];
  assign brownoutLevel      =
    fuse_ff[BROWNOUT_FUSE_IDX][LEVEL_LSB +: 3];
  assign brownoutSampleRate =
    fuse_ff[BROWNOUT_FUSE_IDX][SAMPLE_RATE_BIT];
  assign brownoutActiveMode =
    fuse_ff[BROWNOUT_FUSE_IDX][ACTIVE_MODE_LSB +: 2];
  assign brownoutSleepMode  =
    fuse_ff[BROWNOUT_FUSE_IDX][SLEEP_MODE_LSB +: 2];
  assign timerDFaultControl = fuse_ff[TIMER_D_FUSE_IDX];
  assign crcScanSource      = fuse_ff[SYSTEM_ZERO_IDX][CRC_SRC_LSB +: 2];
  assign resetPinFunction   = fuse_ff[SYSTEM_ZERO_IDX][PIN_FUNC_LSB +: 2];
  assign oscRun20 =
    fuse_ff[OSCILLATOR_FUSE_IDX][OSC_FREQ_LSB +: 2] != FREQ_16MHZ;

  // Zero boot end makes all of flash boot, whatever the app end says
  assign bootEndByte = (fuse_ff[BOOT_END_FUSE_IDX] == 8'h00) ?
    16'(FLASH_BYTES) : blockBytes(fuse_ff[BOOT_END_FUSE_IDX]);
  assign appEndByte = (fuse_ff[APP_END_FUSE_IDX] == 8'h00) ?
    16'(FLASH_BYTES) : blockBytes(fuse_ff[APP_END_FUSE_IDX]);

  // Before load completes the part counts as locked
  assign memoryLocked  = !loaded ||
    (fuse_ff[LOCK_KEY_FUSE_IDX] != UNLOCK_KEY);
  assign debugBusGrant = debugBusReq && !memoryLocked;
  assign eepromErase   = chipErase &&
    (!fuse_ff[SYSTEM_ZERO_IDX][EE_KEEP_BIT] || memoryLocked);

  assign periphResetHold = !loaded;
  assign cpuResetHold    = (state_ff != ST_RUN);

  // Oscillator calibration, factory values loaded once after the image
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      coarse_ff  <= 7'h00;
      tempCal_ff <= 4'h0;
      calLock_ff <= 1'b0;
    end
    else if (state_ff == ST_LOAD && rdIdx_ff > LAST_FUSE_IDX && !capValid_ff)
    begin
      calLock_ff <= fuse_ff[OSCILLATOR_FUSE_IDX][OSC_LOCK_BIT];
      if (fuse_ff[OSCILLATOR_FUSE_IDX][OSC_FREQ_LSB +: 2] == FREQ_16MHZ)
      begin
        coarse_ff  <= factCoarse16;
        tempCal_ff <= factTemp16;
      end
      else
      begin
        coarse_ff  <= factCoarse20;
        tempCal_ff <= factTemp20;
      end
    end
    else if (apbWrite && !calLock_ff)
    begin
      // Locked calibration ignores writes
      if (regIdx == CAL_FIRST_IDX)
        coarse_ff <= pwdata[6:0];
      if (regIdx == CAL_SECOND_IDX)
        tempCal_ff <= pwdata[3:0];
    end
  end

  assign oscCalibrationLock        = calLock_ff;
  assign oscCoarseCalibration      = coarse_ff;
  assign oscTemperatureCalibration = tempCal_ff;

  // Millisecond enable and elapsed count for the start-up delay
  always_ff @(posedge clk)
  begin
    if (srst || state_ff != ST_STARTUP)
      msCnt_ff <= '0;
    else if (msTick)
      msCnt_ff <= '0;
    else
      msCnt_ff <= msCnt_ff + MS_W'(1);
  end

  assign msTick = (msCnt_ff == MS_W'(MS_CYCLES - 1));

  always_ff @(posedge clk)
  begin
    if (srst || state_ff == ST_LOAD)
      msElapsed_ff <= 7'h00;
    else if (msTick && msElapsed_ff != 7'h7F)
      msElapsed_ff <= msElapsed_ff + 7'h01;
  end

  // Slow oscillator: three stages, edge counted once stages 2 and 3 agree
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      slowSync_ff  <= 3'h0;
      slowLevel_ff <= 1'b0;
    end
    else
    begin
      slowSync_ff <= {slowSync_ff[1:0], slowOsc};
      if (slowSync_ff[1] == slowSync_ff[2])
        slowLevel_ff <= slowSync_ff[2];
    end
  end

  assign slowRise = slowSync_ff[1] && slowSync_ff[2] && !slowLevel_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      holdCnt_ff  <= '0;
      holdDone_ff <= 1'b0;
    end
    else if (loaded && !holdDone_ff && slowRise)
    begin
      if (holdCnt_ff == HOLD_W'(HOLD_SLOW - 1))
        holdDone_ff <= 1'b1;
      holdCnt_ff <= holdCnt_ff + HOLD_W'(1);
    end
  end

  // Pin driver free once hold ends; hold only matters for GPIO use
  assign gpioDriveAllowed = loaded && (resetPinFunction == PIN_GPIO) &&
    holdDone_ff;

  // APB slave, zero wait: read data registered in the setup cycle
  assign regIdx   = paddr[7:2];
  assign apbWrite = psel && penable && pwrite;
  assign pready   = psel && penable;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (paddr[1:0] != 2'h0)
        pslverr <= 1'b1;
      else if (regIdx <= 6'(LAST_FUSE_IDX))
      begin
        if (regIdx == 6'h03 || regIdx == 6'h09)
          pslverr <= 1'b1;
        else
          prdata <= {24'h000000, fuse_ff[regIdx[3:0]]};
      end
      else if (regIdx == STATUS_IDX)
        prdata <= {27'h0, gpioDriveAllowed, memoryLocked, calLock_ff,
                   state_ff == ST_RUN, loaded};
      else if (regIdx == CAL_FIRST_IDX)
        prdata <= {25'h0, coarse_ff};
      else if (regIdx == CAL_SECOND_IDX)
        prdata <= {24'h0, calLock_ff, 3'h0, tempCal_ff};
      else
        pslverr <= 1'b1;
    end
  end

  // Checks
  int loadCycles_ff;
  always_ff @(posedge clk)
  begin
    if (srst)
      loadCycles_ff <= 0;
    else if (!loaded)
      loadCycles_ff <= loadCycles_ff + 1;
  end

  load_time_a: assert property (@(posedge clk) disable iff (srst)
    loadCycles_ff <= 14)
    else $error("fuse load took too long");

  release_order_a: assert property (@(posedge clk) disable iff (srst)
    !periphResetHold |-> cpuResetHold || $past(!periphResetHold))
    else $error("processor released before peripherals");

  wdt_copy_a: assert property (@(posedge clk) disable iff (srst)
    capValid_ff && capIdx_ff == WATCHDOG_FUSE_IDX |=>
      {watchdogWindow, watchdogPeriod} == $past(fuseData))
    else $error("watchdog fields not copied");

  brownout_copy_a: assert property (@(posedge clk) disable iff (srst)
    capValid_ff && capIdx_ff == BROWNOUT_FUSE_IDX |=>
      {brownoutLevel, brownoutSampleRate, brownoutActiveMode,
       brownoutSleepMode} == $past(fuseData))
    else $error("brown-out fields not copied");

  cal_locked_a: assert property (@(posedge clk) disable iff (srst)
    loaded && calLock_ff && apbWrite |=> $stable(coarse_ff) &&
      $stable(tempCal_ff))
    else $error("locked calibration modified");

  key_unlock_a: assert property (@(posedge clk) disable iff (srst)
    loaded |-> memoryLocked == (fuse_ff[LOCK_KEY_FUSE_IDX] != UNLOCK_KEY))
    else $error("lock state mismatches key");

  debug_deny_a: assert property (@(posedge clk) disable iff (srst)
    memoryLocked |-> !debugBusGrant)
    else $error("debug granted while locked");

  ee_keep_a: assert property (@(posedge clk) disable iff (srst)
    chipErase && !memoryLocked && fuse_ff[SYSTEM_ZERO_IDX][EE_KEEP_BIT]
      |-> !eepromErase)
    else $error("eeprom erased despite keep");

  pin_hold_a: assert property (@(posedge clk) disable iff (srst)
    gpioDriveAllowed |-> holdCnt_ff == HOLD_W'(HOLD_SLOW))
    else $error("gpio driver freed early");

  boot_zero_a: assert property (@(posedge clk) disable iff (srst)
    fuse_ff[BOOT_END_FUSE_IDX] == 8'h00 |-> bootEndByte == 16'(FLASH_BYTES))
    else $error("zero boot end not whole flash");

  load_done_c: cover property (@(posedge clk) disable iff (srst)
    $rose(loaded));
  run_c: cover property (@(posedge clk) disable iff (srst)
    $fell(cpuResetHold));
  unlock_c: cover property (@(posedge clk) disable iff (srst)
    debugBusGrant);
  pin_free_c: cover property (@(posedge clk) disable iff (srst)
    $rose(gpioDriveAllowed));

endmodule : fuse_config_loader

// [design/fuse_config_pkg.sv]
// Package with fuse map, field positions and timing constants
package fuse_config_pkg;

  localparam logic [3:0] WATCHDOG_FUSE_IDX   = 4'h0;
  localparam logic [3:0] BROWNOUT_FUSE_IDX   = 4'h1;
  localparam logic [3:0] OSCILLATOR_FUSE_IDX = 4'h2;
  localparam logic [3:0] TIMER_D_FUSE_IDX    = 4'h4;
  localparam logic [3:0] SYSTEM_ZERO_IDX     = 4'h5;
  localparam logic [3:0] SYSTEM_ONE_IDX      = 4'h6;
  localparam logic [3:0] APP_END_FUSE_IDX    = 4'h7;
  localparam logic [3:0] BOOT_END_FUSE_IDX   = 4'h8;
  localparam logic [3:0] LOCK_KEY_FUSE_IDX   = 4'hA;
  localparam logic [3:0] LAST_FUSE_IDX       = 4'hA;

  // Own registers beyond the fuse image
  localparam logic [5:0] STATUS_IDX          = 6'h10;
  localparam logic [5:0] CAL_FIRST_IDX       = 6'h11;
  localparam logic [5:0] CAL_SECOND_IDX      = 6'h12;

  localparam int WDT_WINDOW_LSB   = 4;
  localparam int WDT_PERIOD_LSB   = 0;
  localparam int LEVEL_LSB        = 5;
  localparam int SAMPLE_RATE_BIT  = 4;
  localparam int ACTIVE_MODE_LSB  = 2;
  localparam int SLEEP_MODE_LSB   = 0;
  localparam int OSC_LOCK_BIT     = 7;
  localparam int OSC_FREQ_LSB     = 0;
  localparam int CRC_SRC_LSB      = 6;
  localparam int PIN_FUNC_LSB     = 2;
  localparam int EE_KEEP_BIT      = 0;
  localparam int DELAY_LSB        = 0;
  localparam int CAL_LOCK_BIT     = 7;
  localparam int BLOCK_SHIFT      = 8;

  localparam logic [1:0] FREQ_16MHZ     = 2'h1;
  localparam logic [1:0] FREQ_20MHZ     = 2'h2;
  localparam logic [1:0] PIN_GPIO       = 2'h0;
  localparam logic [1:0] PIN_DEBUG      = 2'h1;
  localparam logic [1:0] PIN_RESET      = 2'h2;
  localparam logic [1:0] CRC_FULL       = 2'h0;
  localparam logic [1:0] CRC_BOOT       = 2'h1;
  localparam logic [1:0] CRC_BOOT_APP   = 2'h2;
  localparam logic [1:0] NO_CHECK_CODE  = 2'h3;
  localparam logic [7:0] UNLOCK_KEY     = 8'hC5;

  localparam int CLK_HZ          = 125000000;
  localparam int MS_PER_S        = 1000;
  localparam int CYCLES_PER_MS   = CLK_HZ / MS_PER_S;
  localparam int PIN_HOLD_SLOW   = 768;

  typedef enum logic [1:0] {ST_LOAD, ST_STARTUP, ST_RUN} load_state_type;

endpackage : fuse_config_pkg

// [verif/fuse_array_model.sv]
// Behavioural fuse array: byte appears one cycle after its address
module fuse_array_model
  import fuse_config_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [3:0] fuseAddr,
  output logic      [7:0] fuseData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] image [11];
  // Empty slots give a moving pattern so stale bytes cannot pass
  always @(posedge clk)
  begin
    if (fuseAddr <= LAST_FUSE_IDX && fuseAddr != 4'h3 && fuseAddr != 4'h9)
      fuseData <= image[fuseAddr];
    else
      fuseData <= {fuseAddr, ~fuseAddr};
  end
endmodule : fuse_array_model

// [verif/tb_fuse_config_loader.sv]
// Self-checking bench for the fuse configuration loader
module tb_fuse_config_loader
  import fuse_config_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 10;
  localparam int HOLD = 4;
  localparam int FLASH = 4096;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        slowOsc = 1'b0;
  logic        debugBusReq = 1'b0;
  logic        chipErase = 1'b0;
  logic [6:0]  factCoarse16 = 7'h31;
  logic [3:0]  factTemp16 = 4'h6;
  logic [6:0]  factCoarse20 = 7'h4C;
  logic [3:0]  factTemp20 = 4'h9;
  logic        pready, pslverr, brownoutSampleRate, oscCalibrationLock;
  logic        oscRun20, gpioDriveAllowed, eepromErase, memoryLocked;
  logic        debugBusGrant, periphResetHold, cpuResetHold;
  logic [31:0] prdata;
  logic [3:0]  fuseAddr, watchdogWindow, watchdogPeriod;
  logic [7:0]  fuseData, timerDFaultControl;
  logic [3:0]  oscTemperatureCalibration;
  logic [6:0]  oscCoarseCalibration;
  logic [2:0]  brownoutLevel;
  logic [1:0]  brownoutActiveMode, brownoutSleepMode, crcScanSource;
  logic [1:0]  resetPinFunction;
  logic [15:0] bootEndByte, appEndByte;
  int          numErrors = 0;
  int          checksDone = 0;
  int          cyc = 0;
  int          slowDiv = 0;
  int          rises = 0;
  logic [3:0]  riseDly = 4'h0;
  logic [7:0]  img [4][11] = '{
    '{8'h5A, 8'h5E, 8'h01, 8'h00, 8'hA5, 8'h01, 8'h03, 8'h08, 8'h02, 8'h00, 8'hC5},
    '{8'hF0, 8'hE3, 8'h82, 8'h00, 8'h5A, 8'h44, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h0F, 8'h05, 8'h03, 8'h00, 8'h0F, 8'h89, 8'h00, 8'h00, 8'h04, 8'h00, 8'hC4},
    '{8'h3C, 8'hA8, 8'h00, 8'h00, 8'hF0, 8'hC0, 8'h01, 8'h05, 8'h00, 8'h00, 8'hC5}};

  fuse_config_loader #(.FLASH_BYTES(FLASH), .MS_CYCLES(MSC), .HOLD_SLOW(HOLD))
    i_fuse_config_loader (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .fuseAddr, .fuseData, .factCoarse16,
    .factTemp16, .factCoarse20, .factTemp20, .slowOsc, .debugBusReq,
    .chipErase, .watchdogWindow, .watchdogPeriod, .brownoutLevel,
    .brownoutSampleRate, .brownoutActiveMode, .brownoutSleepMode,
    .oscCalibrationLock, .oscRun20, .oscCoarseCalibration,
    .oscTemperatureCalibration, .timerDFaultControl, .crcScanSource,
    .resetPinFunction, .gpioDriveAllowed, .eepromErase, .bootEndByte,
    .appEndByte, .memoryLocked, .debugBusGrant, .periphResetHold,
    .cpuResetHold);
  fuse_array_model i_fuse_array_model (.clk, .fuseAddr, .fuseData);

  initial
  begin
    forever #4 clk = ~clk;
  end

  // Slow clock of 12 cycles; rises counted after the synchroniser's lag
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    slowDiv <= (slowDiv == 5) ? 0 : slowDiv + 1;
    if (slowDiv == 5)
      slowOsc <= ~slowOsc;
    riseDly <= {riseDly[2:0], slowDiv == 5 && !slowOsc};
    if (periphResetHold)
      rises <= 0;
    else if (riseDly[3])
      rises <= rises + 1;
  end

  task automatic printVerdict();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : printVerdict

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      numErrors++;
      printVerdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg8(input logic wr, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
    logic err;
    apb(wr, {idx, 2'b00}, {24'h0, wd}, rd, err);
    check("slverr", err, 1'b0);
  endtask : reg8

  task automatic runImage(input int k);
    logic [7:0]  f [11];
    logic [31:0] rd;
    logic        err;
    logic        lk;
    logic        gp;
    int          i;
    int          t0;
    int          ms;
    int          idx [9] = '{0, 1, 2, 4, 5, 6, 7, 8, 10};
    f = img[k];
    lk = (f[10] != UNLOCK_KEY);
    gp = (f[5][3:2] == PIN_GPIO);
    ms = (f[6][2:0] == 3'h0) ? 0 : 1 << (f[6][2:0] - 1);
    i_fuse_array_model.image = f;
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("inReset", {memoryLocked, periphResetHold, cpuResetHold}, 3'h7);
    @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 60 && periphResetHold !== 1'b0; i++)
      @(posedge clk);
    if (i == 60)
    begin
      numErrors++;
      printVerdict();
    end
    t0 = cyc;
    @(negedge clk);
    check("wdt", {watchdogWindow, watchdogPeriod}, f[0]);
    check("brLevel", brownoutLevel, f[1][7:5]);
    check("brRate", brownoutSampleRate, f[1][4]);
    check("brActive", brownoutActiveMode, f[1][3:2]);
    check("brSleep", brownoutSleepMode, f[1][1:0]);
    check("osc_calibration_lock", oscCalibrationLock, f[2][7]);
    check("osc20", oscRun20, f[2][1:0] != FREQ_16MHZ);
    check("coarse", oscCoarseCalibration,
          (f[2][1:0] == FREQ_16MHZ) ? factCoarse16 : factCoarse20);
    check("temp", oscTemperatureCalibration,
          (f[2][1:0] == FREQ_16MHZ) ? factTemp16 : factTemp20);
    check("tcd", timerDFaultControl, f[4]);
    check("crc", crcScanSource, f[5][7:6]);
    check("pin", resetPinFunction, f[5][3:2]);
    check("boot", bootEndByte, (f[8] == 0) ? FLASH : {f[8], 8'h00});
    check("app", appEndByte, (f[7] == 0) ? FLASH : {f[7], 8'h00});
    check("locked", memoryLocked, lk);
    check("gpioOff", gpioDriveAllowed, 1'b0);
    for (i = 0; i < 1000 && cpuResetHold !== 1'b0; i++)
      @(posedge clk);
    check("startup", (cyc - t0 >= ms * MSC - 1) && (cyc - t0 <= ms * MSC + 3),
          1'b1);
    for (i = 0; i < 150 && gpioDriveAllowed !== 1'b1; i++)
      @(posedge clk);
    check("gpioOn", gpioDriveAllowed, gp);
    if (gp)
      check("holdLen", rises >= HOLD && rises <= HOLD + 1, 1'b1);
    foreach (idx[j])
    begin
      reg8(1'b0, 6'(idx[j]), 8'h00, rd);
      check("fuseReg", rd, f[idx[j]]);
    end
    apb(1'b0, 8'h0C, 32'h0, rd, err);
    check("hole", err, 1'b1);
    apb(1'b0, 8'h02, 32'h0, rd, err);
    check("misalign", err, 1'b1);
    reg8(1'b1, 6'h00, ~f[0], rd);
    reg8(1'b0, 6'h00, 8'h00, rd);
    check("roFuse", rd, f[0]);
    reg8(1'b0, STATUS_IDX, 8'h00, rd);
    check("status", rd, {gp, lk, f[2][7], 2'b11});
    reg8(1'b1, CAL_FIRST_IDX, 8'h2A, rd);
    @(negedge clk);
    check("calWr", oscCoarseCalibration, f[2][7] ? ((f[2][1:0] == FREQ_16MHZ)
          ? factCoarse16 : factCoarse20) : 7'h2A);
    reg8(1'b1, CAL_SECOND_IDX, 8'h05, rd);
    reg8(1'b0, CAL_SECOND_IDX, 8'h00, rd);
    check("calRd", rd, {f[2][7], 3'h0, f[2][7] ? ((f[2][1:0] ==
          FREQ_16MHZ) ? factTemp16 : factTemp20) : 4'h5});
    @(posedge clk);
    debugBusReq <= 1'b1;
    chipErase <= 1'b1;
    @(negedge clk);
    check("grant", debugBusGrant, !lk);
    check("erase", eepromErase, !f[5][0] || lk);
    reg8(1'b1, 6'(LOCK_KEY_FUSE_IDX), 8'h00, rd);
    @(negedge clk);
    check("relock", {memoryLocked, debugBusGrant, eepromErase}, 3'h5);
    reg8(1'b1, 6'(LOCK_KEY_FUSE_IDX), UNLOCK_KEY, rd);
    @(negedge clk);
    check("unlock", {memoryLocked, debugBusGrant, eepromErase},
          {2'b01, !f[5][0]});
    @(posedge clk);
    debugBusReq <= 1'b0;
    chipErase <= 1'b0;
  endtask : runImage

  initial
  begin
    #800000;
    numErrors++;
    printVerdict();
  end

  initial
  begin
    for (int k = 0; k < 4; k++)
      runImage(k);
    printVerdict();
  end
endmodule : tb_fuse_config_loader
